// ===== rtl/iipif_pkg.sv
// Package for the 32-channel isolated input port with edge interrupts.
// Assumes one 200 MHz clock and a 32-bit Avalon-MM register slave.
package iipif_pkg;

   localparam int NUM_CH = 32;
   localparam int ADDR_W = 5;

   // Register byte offsets, one aligned word each.
   localparam logic [4:0] REG_DATA = 5'h00;
   localparam logic [4:0] REG_IRQ_EN = 5'h04;
   localparam logic [4:0] REG_EDGE_SEL = 5'h08;
   localparam logic [4:0] REG_PENDING = 5'h0C;
   localparam logic [4:0] REG_FILTER = 5'h10;
   localparam logic [4:0] REG_RAW = 5'h14;

   // Filter control field layout.
   localparam int FILT_LEN_LSB = 0;
   localparam int FILT_LEN_W = 16;

   // Reset values.
   localparam logic [31:0] IRQ_EN_RST = 32'h0000_0000;
   localparam logic [31:0] EDGE_SEL_RST = 32'h0000_0000;
   localparam logic [15:0] FILT_LEN_RST = 16'h0000;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   // Input response time in ns, and its budget in clock cycles.
   localparam int CLK_PERIOD_PS = 5000;
   localparam int RESP_TIME_NS = 200000;
   localparam int RESP_CYCLES = (RESP_TIME_NS * 1000) / CLK_PERIOD_PS;

   // Synchroniser depth on field inputs.
   localparam int SYNC_STAGES = 3;

   // Bus slave states, one-hot.
   typedef enum logic [1:0] {
      IIPIF_IDLE = 2'b01,
      IIPIF_ACK = 2'b10
   } iipif_bus_state_t;

endpackage : iipif_pkg

// ===== rtl/iipif_chan.sv
// One input channel: synchroniser, chatter filter and edge detector.
// Assumes the field level arrives asynchronously to ref_clk.
`timescale 1ns/1ps
module iipif_chan #(
   parameter int FILT_W = 16
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic field_in,
   input wire logic [FILT_W-1:0] filt_len,
   output logic state_bit,
   output logic raw_bit,
   output logic rise_pulse,
   output logic fall_pulse
);

   initial begin
      if (FILT_W < 1 || FILT_W > 24) begin
         $error("iipif_chan: FILT_W out of range");
      end
   end

   logic sync1_reg;
   logic sync2_reg;
   logic sync3_reg;
   logic raw_reg;
   logic [FILT_W-1:0] cnt_reg;
   logic [FILT_W-1:0] cnt_next;
   logic state_reg;
   logic state_next;
   logic stable_done;
   logic differs;

   // raw_reg only takes a change from the third stage once the two later stages agree.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
         raw_reg <= 1'b0;
      end else begin
         sync1_reg <= ~field_in; // see RULE_02
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         if (sync2_reg == sync3_reg) begin
            raw_reg <= sync3_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // A zero filter length passes the level straight on; otherwise the new
   // level must hold for filt_len + 1 cycles, so chatter never reaches state.
   assign differs = (raw_reg != state_reg);
   assign stable_done = (cnt_reg >= filt_len);
   assign cnt_next = !differs ? '0 :
                     stable_done ? '0 : cnt_reg + 1'b1;
   assign state_next = (differs && stable_done) ? raw_reg : state_reg;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_reg <= '0;
         state_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next; // see RULE_07
         state_reg <= state_next; // see RULE_08
      end
   end

   assign state_bit = state_reg; // see RULE_03
   assign raw_bit = raw_reg;
   assign rise_pulse = state_next & ~state_reg;
   assign fall_pulse = ~state_next & state_reg;

endmodule : iipif_chan

// ===== rtl/iipif_top.sv
// Top of the 32-channel isolated input port with per-bit edge interrupts.
// Assumes field inputs are active-low opto outputs, asynchronous to
// ref_clk, and a host reaching registers over Avalon-MM with waitrequest.
//
// Behaviour
// RULE_01 - Thirty-two input bits readable by host, each an interrupt source.
// RULE_02 - Negative logic: high field level reads 0, low level reads 1.
// RULE_03 - Closed switch, current flowing, reads 1; open switch reads 0.
// RULE_04 - Per-bit interrupt enable; a disabled bit never raises the request.
// RULE_05 - Per-bit choice of rising or falling edge as interrupt trigger.
// RULE_06 - All channel interrupts merge into one legacy INTA request line.
// RULE_07 - Software-programmable noise and chatter filter on every input.
// RULE_08 - Input change shows in data bit within 200 us, plus filter delay.
// RULE_09 - Enabled edges latch per-bit flags; request holds until cleared. Clearing a pending bit's enable also drops the request here.
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module iipif_top #(
   parameter int NUM_CH = iipif_pkg::NUM_CH,
   parameter int FILT_W = iipif_pkg::FILT_LEN_W
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [NUM_CH-1:0] field_in_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic inta_req
);

   initial begin
      if (NUM_CH < 1 || NUM_CH > 32) begin
         $error("iipif_top: NUM_CH must be 1 to 32");
      end
      if (FILT_W != iipif_pkg::FILT_LEN_W) begin
         $error("iipif_top: FILT_W must match the filter field");
      end
      if (iipif_pkg::SYNC_STAGES + 2 > iipif_pkg::RESP_CYCLES) begin
         $error("iipif_top: response budget too small");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channels.

   logic [NUM_CH-1:0] state_vec;
   logic [NUM_CH-1:0] raw_vec;
   logic [NUM_CH-1:0] rise_vec;
   logic [NUM_CH-1:0] fall_vec;
   logic [FILT_W-1:0] filt_len_reg;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         iipif_chan #(
            .FILT_W(FILT_W)
         ) u_chan (
            .ref_clk(ref_clk),
            .srst(srst),
            .field_in(field_in_n[gi]),
            .filt_len(filt_len_reg),
            .state_bit(state_vec[gi]), // see RULE_01
            .raw_bit(raw_vec[gi]),
            .rise_pulse(rise_vec[gi]),
            .fall_pulse(fall_vec[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Bus slave. Every access answers one cycle after it is seen, which
   // keeps read data registered and the write strobe a single pulse.

   iipif_pkg::iipif_bus_state_t st_reg;
   iipif_pkg::iipif_bus_state_t st_next;
   logic req_seen;
   logic wr_fire;
   logic rd_fire;
   logic [31:0] be_mask;
   logic [31:0] rd_mux;
   logic [31:0] readdata_reg;

   assign req_seen = avs_read | avs_write;
   assign wr_fire = avs_write && (st_reg == iipif_pkg::IIPIF_ACK);
   assign rd_fire = avs_read && (st_reg == iipif_pkg::IIPIF_IDLE);
   assign avs_waitrequest = req_seen && (st_reg != iipif_pkg::IIPIF_ACK);
   assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_comb begin
      case (st_reg)
         iipif_pkg::IIPIF_IDLE: begin
            st_next = req_seen ? iipif_pkg::IIPIF_ACK : iipif_pkg::IIPIF_IDLE;
         end
         iipif_pkg::IIPIF_ACK: begin
            st_next = iipif_pkg::IIPIF_IDLE;
         end
         default: begin
            st_next = iipif_pkg::IIPIF_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_reg <= iipif_pkg::IIPIF_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers.

   logic [31:0] irq_en_reg;
   logic [31:0] edge_sel_reg;
   logic [31:0] pending_reg;
   logic [31:0] pending_next;
   logic [31:0] edge_hit;
   logic [31:0] clear_mask;
   logic [31:0] state_w;
   logic [31:0] raw_w;
   logic wr_en;
   logic wr_sel;
   logic wr_pend;
   logic wr_filt;

   assign state_w = 32'(state_vec);
   assign raw_w = 32'(raw_vec);
   assign wr_en = wr_fire && (avs_address == iipif_pkg::REG_IRQ_EN);
   assign wr_sel = wr_fire && (avs_address == iipif_pkg::REG_EDGE_SEL);
   assign wr_pend = wr_fire && (avs_address == iipif_pkg::REG_PENDING);
   assign wr_filt = wr_fire && (avs_address == iipif_pkg::REG_FILTER);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq_en_reg <= iipif_pkg::IRQ_EN_RST;
         edge_sel_reg <= iipif_pkg::EDGE_SEL_RST;
         filt_len_reg <= iipif_pkg::FILT_LEN_RST;
      end else begin
         if (wr_en) begin
            irq_en_reg <= (irq_en_reg & ~be_mask) | (avs_writedata & be_mask);
         end
         if (wr_sel) begin
            edge_sel_reg <= (edge_sel_reg & ~be_mask) |
                            (avs_writedata & be_mask);
         end
         if (wr_filt) begin
            filt_len_reg <= (filt_len_reg & be_mask[FILT_W-1:0]) ^
                            filt_len_reg ^
                            (avs_writedata[iipif_pkg::FILT_LEN_LSB +: FILT_W]
                             & be_mask[FILT_W-1:0]); // see RULE_07
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge capture. A bit set to 1 in edge_sel picks the rising edge of the
   // data bit, 0 picks the falling edge. A new edge in the cycle of a
   // write-one-to-clear keeps its flag, so no event is ever lost.

   assign edge_hit = ((32'(rise_vec) & edge_sel_reg) |
                      (32'(fall_vec) & ~edge_sel_reg)) &
                     irq_en_reg; // see RULE_05 see RULE_04
   assign clear_mask = wr_pend ? (avs_writedata & be_mask) : 32'h0000_0000;
   assign pending_next = (pending_reg & ~clear_mask) | edge_hit; // see RULE_09

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pending_reg <= 32'h0000_0000;
         inta_req <= 1'b0;
      end else begin
         pending_reg <= pending_next;
         // Pending flags of disabled bits stay readable but do not raise
         // the line, so masking a bit drops the line one clock after the write.
         inta_req <= |(pending_next & irq_en_reg); // see RULE_06 see RULE_04
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path.

   assign rd_mux =
      (avs_address == iipif_pkg::REG_DATA) ? state_w :
      (avs_address == iipif_pkg::REG_IRQ_EN) ? irq_en_reg :
      (avs_address == iipif_pkg::REG_EDGE_SEL) ? edge_sel_reg :
      (avs_address == iipif_pkg::REG_PENDING) ? pending_reg :
      (avs_address == iipif_pkg::REG_FILTER) ? 32'(filt_len_reg) :
      (avs_address == iipif_pkg::REG_RAW) ? raw_w :
      iipif_pkg::UNMAPPED_READ;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         readdata_reg <= 32'h0000_0000;
      end else if (rd_fire) begin
         readdata_reg <= rd_mux; // see RULE_01 see RULE_03
      end
   end

   assign avs_readdata = readdata_reg;

endmodule : iipif_top

// ===== dv/iipif_monitor.sv
// Checker for the bus handshake and interrupt pins of iipif_top.
// Assumes one clock domain and a bind onto every iipif_top.
`timescale 1ns/1ps
module iipif_monitor #(
   parameter int NUM_CH = 32
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [NUM_CH-1:0] field_in_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic inta_req
);
   logic req;
   logic [NUM_CH-1:0] fld_reg;
   logic [7:0] quiet_reg;
   assign req = avs_read | avs_write;
   // Cycles since the field last moved; an edge flag needs a recent cause.
   always_ff @(posedge ref_clk) begin
      fld_reg <= field_in_n;
      if (srst || fld_reg != field_in_n) quiet_reg <= 8'h00;
      else if (quiet_reg != 8'hFF) quiet_reg <= quiet_reg + 8'h01;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////
   property p_wait_first; $rose(req) |-> avs_waitrequest; endproperty
   a_wait_first: assert property (p_wait_first)
      else $error("no wait state on a new request");
   property p_answer; req |-> ##[0:1] (req && !avs_waitrequest); endproperty
   a_answer: assert property (p_answer)
      else $error("request not answered in time");
   property p_idle; !req |-> !avs_waitrequest; endproperty
   a_idle: assert property (p_idle)
      else $error("waitrequest without a request");
   property p_one_wait; avs_waitrequest |=> !avs_waitrequest; endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("waitrequest held two cycles");
   property p_b2b; (req && !avs_waitrequest) ##1 req |-> avs_waitrequest;
   endproperty
   a_b2b: assert property (p_b2b)
      else $error("back to back request not stalled");
   property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved without a read");
   property p_irq_cause;
      $rose(inta_req) |-> quiet_reg < 8'h40 || $past(avs_write) ||
         $past(avs_write, 2);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt raised without a cause");
   property p_irq_clear;
      $fell(inta_req) |-> $past(avs_write) || $past(avs_write, 2);
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("interrupt dropped without a write");
endmodule : iipif_monitor
bind iipif_top iipif_monitor #(.NUM_CH(NUM_CH)) iipif_monitor_i (
   .ref_clk, .srst, .field_in_n, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .inta_req);

// ===== dv/iipif_field_sw.sv
// Bank of field switches wired to the isolated inputs.
// Assumes the testbench says which switches are closed.
`timescale 1ns/1ps
module iipif_field_sw (
   input wire logic [31:0] sw_closed,
   output logic [31:0] field_in_n
);
   // Current through a closed switch pulls the input low.
   assign field_in_n = ~sw_closed;
endmodule : iipif_field_sw

// ===== dv/tb.sv
// Self-checking bench for the isolated input port.
// Assumes the field switch model and the bound bus checker.
`timescale 1ns/1ps
module tb;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [31:0] sw = 32'h0, fld_n, rd, exp_p, en, es;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, inta_req;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [3:0] avs_byteenable = 4'hF;
   int fails = 0, num_checks = 0;
   always #2.5 ref_clk = ~ref_clk;
   iipif_field_sw iipif_field_sw_i (.sw_closed(sw), .field_in_n(fld_n));
   iipif_top iipif_top_i (.ref_clk, .srst, .field_in_n(fld_n),
      .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .inta_req);
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] exp_bits(logic [31:0] f);
      return ~f;
   endfunction : exp_bits
   function automatic logic [31:0] exp_pend(logic [31:0] o, logic [31:0] n,
      logic [31:0] e, logic [31:0] s);
      return e & ((s & ~o & n) | (~s & o & ~n));
   endfunction : exp_pend
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(logic w, logic [4:0] a, logic [31:0] d,
      logic [3:0] be);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !w;
      avs_write <= w;
      // Only the watchdog ends a stuck wait, so a stuck slave still reaches the
      // verdict through the closing task.
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   // Twenty cycles is far inside the response budget yet covers sync.
   task automatic set_sw(logic [31:0] v);
      @(posedge ref_clk);
      sw <= v;
      repeat (20) @(posedge ref_clk);
   endtask : set_sw
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(88133));
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      bus(1'b1, 5'h18, 32'hFFFF_FFFF, 4'hF);
      for (int a = 1; a < 8; a++) begin
         bus(1'b0, 5'(a * 4), 32'h0, 4'hF);
         chk("reset_reg", 32'h0, rd);
      end
      for (int i = 0; i < 10; i++) begin
         set_sw(i == 0 ? 32'hFFFF_FFFF : $urandom);
         bus(1'b0, iipif_pkg::REG_DATA, 32'h0, 4'hF);
         chk("data", exp_bits(fld_n), rd);
         bus(1'b0, iipif_pkg::REG_RAW, 32'h0, 4'hF);
         chk("raw", exp_bits(fld_n), rd);
      end
      for (int i = 0; i < 5; i++) begin
         en = (i == 0) ? 32'h0 : $urandom;
         es = $urandom;
         set_sw(32'h0);
         bus(1'b1, iipif_pkg::REG_IRQ_EN, en, 4'hF);
         bus(1'b1, iipif_pkg::REG_EDGE_SEL, es, 4'hF);
         bus(1'b1, iipif_pkg::REG_PENDING, 32'hFFFF_FFFF, 4'hF);
         exp_p = exp_pend(32'h0, 32'hFFFF_FFFF, en, es);
         set_sw(32'hFFFF_FFFF);
         bus(1'b0, iipif_pkg::REG_PENDING, 32'h0, 4'hF);
         chk("pend_rise", exp_p, rd);
         chk("inta_rise", {31'h0, |exp_p}, {31'h0, inta_req});
         exp_p = exp_p | exp_pend(32'hFFFF_FFFF, 32'h0, en, es);
         set_sw(32'h0);
         bus(1'b0, iipif_pkg::REG_PENDING, 32'h0, 4'hF);
         chk("pend_fall", exp_p, rd);
         chk("inta_fall", {31'h0, |exp_p}, {31'h0, inta_req});
         // Masking every bit must drop the line yet keep the flags readable.
         bus(1'b1, iipif_pkg::REG_IRQ_EN, 32'h0, 4'hF);
         bus(1'b0, iipif_pkg::REG_PENDING, 32'h0, 4'hF);
         chk("pend_mask", exp_p, rd);
         chk("inta_mask", 32'h0, {31'h0, inta_req});
         bus(1'b1, iipif_pkg::REG_IRQ_EN, en, 4'hF);
         bus(1'b0, iipif_pkg::REG_PENDING, 32'h0, 4'hF);
         chk("inta_unmask", {31'h0, |exp_p}, {31'h0, inta_req});
         bus(1'b1, iipif_pkg::REG_PENDING, exp_p, 4'hF);
         bus(1'b0, iipif_pkg::REG_PENDING, 32'h0, 4'hF);
         chk("pend_clr", 32'h0, rd);
         chk("inta_clr", 32'h0, {31'h0, inta_req});
      end
      bus(1'b1, iipif_pkg::REG_IRQ_EN, 32'h1, 4'hF);
      bus(1'b1, iipif_pkg::REG_EDGE_SEL, 32'h1, 4'hF);
      bus(1'b1, iipif_pkg::REG_FILTER, 32'h0000_FF08, 4'h1);
      bus(1'b0, iipif_pkg::REG_FILTER, 32'h0, 4'hF);
      chk("filter", 32'h8, rd);
      @(posedge ref_clk);
      sw <= 32'h1;
      repeat (3) @(posedge ref_clk);
      sw <= 32'h0;
      repeat (30) @(posedge ref_clk);
      bus(1'b0, iipif_pkg::REG_PENDING, 32'h0, 4'hF);
      chk("glitch", 32'h0, rd);
      set_sw(32'h1);
      bus(1'b0, iipif_pkg::REG_DATA, 32'h0, 4'hF);
      chk("filt_data", exp_bits(fld_n), rd);
      bus(1'b0, iipif_pkg::REG_PENDING, 32'h0, 4'hF);
      chk("filt_pend", 32'h1, rd);
      tally_and_finish();
   end
endmodule : tb
